// >>> logic/cwf_regs.vh
`ifndef CWF_REGS_VH
`define CWF_REGS_VH
// Transceiver mode codes
`define CWF_TRX_OFF      2'h0
`define CWF_TRX_WAKE     2'h1
`define CWF_TRX_RXONLY   2'h2
`define CWF_TRX_NORMAL   2'h3
// Chip mode codes, one-hot
`define CWF_CHIP_NORMAL  5'h01
`define CWF_CHIP_STOP    5'h02
`define CWF_CHIP_SLEEP   5'h04
`define CWF_CHIP_RESTART 5'h08
`define CWF_CHIP_FAIL    5'h10
// Wake status field position
`define CWF_WK_BUS_BIT   0
// Reset values
`define CWF_TRX_RST      `CWF_TRX_OFF
`define CWF_CHIP_RST     `CWF_CHIP_NORMAL
`define CWF_STATUS_RST   8'h00
// Timing in microseconds at a 10 MHz clock
`define CWF_CLK_MHZ      10
`define CWF_WAKE_MIN_US  2
`define CWF_WAKE_MAX_US  1000
`define CWF_TXTO_US      2000
`define CWF_BUSTO_US     2000
`define CWF_WAKE_MIN_CYC (`CWF_WAKE_MIN_US * `CWF_CLK_MHZ)
`define CWF_WAKE_MAX_CYC (`CWF_WAKE_MAX_US * `CWF_CLK_MHZ)
`define CWF_TXTO_CYC     (`CWF_TXTO_US * `CWF_CLK_MHZ)
`define CWF_BUSTO_CYC    (`CWF_BUSTO_US * `CWF_CLK_MHZ)
`endif

// >>> logic/cwf_can_wake_fault.v
`timescale 1ns/1ps
`include "cwf_regs.vh"
module cwf_can_wake_fault #(
  parameter WAKE_MIN_CYC  = `CWF_WAKE_MIN_CYC,
  parameter WAKE_MAX_CYC  = `CWF_WAKE_MAX_CYC,
  parameter TXTO_CYC      = `CWF_TXTO_CYC,
  parameter BUSTO_CYC     = `CWF_BUSTO_CYC,
  parameter CW            = 16
) (
  input  wire       mclk,
  input  wire       resetn,
  input  wire [1:0] trx_mode_wdata,
  input  wire       trx_mode_we,
  input  wire [4:0] chip_mode_wdata,
  input  wire       chip_mode_we,
  input  wire       restart_done,
  input  wire       wake_flag_clr,
  input  wire       fail_flag_clr,
  input  wire       uv_flag_clr,
  input  wire       wdog_on_bus_wake_cfg,
  input  wire       wdog_en_wdata,
  input  wire       wdog_en_we,
  input  wire       bus_dominant,
  input  wire       can_rx_bus,
  input  wire       can_tx_in,
  input  wire       can_supply_ok,
  output reg  [1:0] trx_mode_r,
  output reg  [4:0] chip_mode_r,
  output reg        can_rx_out,
  output reg        can_tx_drive_r,
  output reg        interrupt_n_out,
  output reg        can_wake_flag,
  output reg  [7:0] wake_status_reg,
  output reg        can_failure_flag,
  output reg        can_supply_low_flag,
  output reg        can_supply_en_r,
  output reg        wdog_en_r
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoded state
  wire in_wake   = (trx_mode_r == `CWF_TRX_WAKE);
  wire in_normal = (trx_mode_r == `CWF_TRX_NORMAL);
  wire in_rxonly = (trx_mode_r == `CWF_TRX_RXONLY);
  // Stop rewrite in Stop, or entry into Stop, rearms
  wire stop_wr   = chip_mode_we && (chip_mode_wdata == `CWF_CHIP_STOP);
  wire fail_wr   = chip_mode_we && (chip_mode_wdata == `CWF_CHIP_FAIL) &&
                   (chip_mode_r != `CWF_CHIP_FAIL);
  // Any mode write away from wake-capable forgets the woken state
  wire trx_leave = trx_mode_we && (trx_mode_wdata != `CWF_TRX_WAKE);
  wire rearm     = stop_wr || fail_wr || trx_leave || wake_flag_clr;

  ////////////////////////////////////////////////////////////////////////////
  // Wake pattern detector
  localparam P_IDLE = 4'h1;
  localparam P_DOM1 = 4'h2;
  localparam P_REC  = 4'h4;
  localparam P_DOM2 = 4'h8;
  reg [3:0]    pat_r;
  reg [3:0]    pat_nxt;
  reg [CW-1:0] pcnt_r;
  reg          prev_dom_r;
  reg          woken_r;
  reg          wake_hit;
  // Window bounds are strict on both sides; a phase of exactly the
  // minimum or maximum length does not count
  wire         win_lo   = (pcnt_r > WAKE_MIN_CYC[CW-1:0]);
  wire         win_hi   = (pcnt_r < WAKE_MAX_CYC[CW-1:0]);
  wire         in_win   = win_lo && win_hi;
  wire         edge_now = (bus_dominant != prev_dom_r);
  wire         armed    = in_wake && !woken_r;

  // Phase tracking; a phase length is checked when the level changes
  always @* begin
    pat_nxt  = pat_r;
    wake_hit = 1'b0;
    case (pat_r)
      P_IDLE: if (bus_dominant) pat_nxt = P_DOM1;
      P_DOM1: if (edge_now) pat_nxt = in_win ? P_REC : P_IDLE;
      P_REC: begin
        if (edge_now) pat_nxt = in_win ? P_DOM2 : P_DOM1;
        else if (!in_win && pcnt_r >= WAKE_MAX_CYC[CW-1:0]) pat_nxt = P_IDLE;
      end
      P_DOM2: if (edge_now) begin
        pat_nxt  = P_IDLE;
        wake_hit = in_win;
      end
      default: pat_nxt = P_IDLE;
    endcase
    if (!armed) begin
      pat_nxt  = P_IDLE;
      wake_hit = 1'b0;
    end
  end

  // Phase counter saturates to avoid wrapping on long phases
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pat_r      <= P_IDLE;
      pcnt_r     <= {CW{1'b0}};
      prev_dom_r <= 1'b0;
    end else begin
      pat_r      <= pat_nxt;
      prev_dom_r <= bus_dominant;
      if (edge_now || !armed)
        pcnt_r <= {{(CW-1){1'b0}}, 1'b1};
      else if (pcnt_r != {CW{1'b1}})
        pcnt_r <= pcnt_r + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault counters for tx time-out and bus clamping
  reg [CW-1:0] txc_r;
  reg [CW-1:0] busc_r;
  wire tx_to  = (txc_r  > TXTO_CYC[CW-1:0]);
  wire bus_to = (busc_r > BUSTO_CYC[CW-1:0]);
  // Tx dominant run length; dominant tx is low, counts only in normal mode
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      txc_r <= {CW{1'b0}};
    end else if (!in_normal || can_tx_in) begin
      txc_r <= {CW{1'b0}};
    end else if (!tx_to) begin
      txc_r <= txc_r + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // Bus dominant run length in normal and receive-only modes
  // Stops one past the limit so a clamp held for long cannot wrap
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      busc_r <= {CW{1'b0}};
    end else if (!(in_normal || in_rxonly) || !bus_dominant) begin
      busc_r <= {CW{1'b0}};
    end else if (!bus_to) begin
      busc_r <= busc_r + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode control, flags and outputs
  // Supply is watched only while the driver may be active
  wire sup_mon   = in_normal || in_rxonly;
  wire uv_now    = sup_mon && !can_supply_ok;
  // Chip modes that stay up on a bus wake and raise the interrupt
  wire chip_up   = (chip_mode_r == `CWF_CHIP_STOP) ||
                   (chip_mode_r == `CWF_CHIP_NORMAL);
  // Chip modes that a bus wake sends to Restart
  wire chip_down = (chip_mode_r == `CWF_CHIP_SLEEP) ||
                   (chip_mode_r == `CWF_CHIP_FAIL) ||
                   (chip_mode_r == `CWF_CHIP_RESTART);
  // Wake writes refused in Fail-Safe, whose entry already forces it
  wire trx_wr_ok = trx_mode_we &&
                   ((trx_mode_wdata != `CWF_TRX_WAKE) ||
                    (chip_mode_r != `CWF_CHIP_FAIL));

  ////////////////////////////////////////////////////////////////////////////
  // Transceiver mode register
  // Only the host and Fail-Safe entry move it; faults never touch it
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      trx_mode_r <= `CWF_TRX_RST;
    end else if (fail_wr) begin
      trx_mode_r <= `CWF_TRX_WAKE;
    end else if (trx_wr_ok) begin
      trx_mode_r <= trx_mode_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Chip mode: a bus wake from Sleep, Fail or Restart beats a host write in the same cycle
  // Stop and Normal never change by themselves on a wake
  // Restart hands over to Normal once the supplies report ready
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      chip_mode_r <= `CWF_CHIP_RST;
    end else if (wake_hit && chip_down) begin
      chip_mode_r <= `CWF_CHIP_RESTART;
    end else if (chip_mode_we) begin
      chip_mode_r <= chip_mode_wdata;
    end else if ((chip_mode_r == `CWF_CHIP_RESTART) && restart_done) begin
      chip_mode_r <= `CWF_CHIP_NORMAL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Woken state; a wake in the same cycle as a rearm wins
  // While woken the detector is held idle, so repeats are ignored
  // Mode field keeps the wake code; only this bit marks the wake
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      woken_r <= 1'b0;
    end else if (wake_hit) begin
      woken_r <= 1'b1;
    end else if (rearm) begin
      woken_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus wake flag; only the host clears it
  // A clear that meets a new wake loses, so no wake goes unseen
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      can_wake_flag <= 1'b0;
    end else if (wake_hit) begin
      can_wake_flag <= 1'b1;
    end else if (wake_flag_clr) begin
      can_wake_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus wake source bit of the status image
  // Other status bits belong to other wake sources
  // and are left at their reset level here
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wake_status_reg <= `CWF_STATUS_RST;
    end else if (wake_hit) begin
      wake_status_reg[`CWF_WK_BUS_BIT] <= 1'b1;
    end else if (wake_flag_clr) begin
      wake_status_reg[`CWF_WK_BUS_BIT] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt only where the chip stays up; a wake out of Sleep
  // reaches the host through the rx pin alone
  // The wake flag clear is also what releases the line
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      interrupt_n_out <= 1'b1;
    end else if (wake_hit && chip_up) begin
      interrupt_n_out <= 1'b0;
    end else if (wake_flag_clr) begin
      interrupt_n_out <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog enable; a Stop wake forces it on when configured
  // A host write in the same cycle loses, so safety comes first
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wdog_en_r <= 1'b0;
    end else if (wake_hit && (chip_mode_r == `CWF_CHIP_STOP) && wdog_on_bus_wake_cfg) begin
      wdog_en_r <= 1'b1;
    end else if (wdog_en_we) begin
      wdog_en_r <= wdog_en_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rx pin: held low while woken and the mode stays wake-capable
  // Outside the active modes it rests high, so no false low reaches the host
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      can_rx_out <= 1'b1;
    end else if (wake_hit || (woken_r && in_wake && !trx_leave)) begin
      can_rx_out <= 1'b0;
    end else if (sup_mon) begin
      can_rx_out <= can_rx_bus;
    end else begin
      can_rx_out <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Failure flag; a long dominant tx or bus sets it
  // The set wins over a clear, so a lasting fault stays visible
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      can_failure_flag <= 1'b0;
    end else if (tx_to || bus_to) begin
      can_failure_flag <= 1'b1;
    end else if (fail_flag_clr) begin
      can_failure_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Supply low flag; only judged while the driver may be active
  // A clear while the supply is still low is overridden at once
  // Wake-capable mode runs from an internal supply and is not judged
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      can_supply_low_flag <= 1'b0;
    end else if (uv_now) begin
      can_supply_low_flag <= 1'b1;
    end else if (uv_flag_clr) begin
      can_supply_low_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tx forced recessive on time-out or undervoltage; recovers by itself
  // Mode bits stay as written, so recovery needs no host action
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      can_tx_drive_r <= 1'b1;
    end else begin
      can_tx_drive_r <= !(in_normal && !tx_to && !uv_now && !can_tx_in);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Supply enable: off while armed, on once a wake is seen
  // Off mode keeps it off; the other modes need it for the driver
  // The wake cycle itself counts, so the supply starts one cycle sooner
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      can_supply_en_r <= 1'b0;
    end else if (in_wake) begin
      can_supply_en_r <= woken_r || wake_hit;
    end else begin
      can_supply_en_r <= (trx_mode_r != `CWF_TRX_OFF);
    end
  end

endmodule

// >>> sim/cwf_bus_model.sv
`timescale 1ns/1ps
// Bus side: dom/rec/dom phases of equal length on go, or a held clamp
module cwf_bus_model (
  input  wire logic       mclk,
  input  wire logic       go,
  input  wire logic       clamp,
  input  wire logic [4:0] len,
  output logic            dom
);
  logic [6:0] cnt_r = 7'h0;
  // Phase counter; bus rests recessive between patterns
  always @(posedge mclk) begin
    if (go) cnt_r <= 7'h1;
    else if (cnt_r != 7'h0) cnt_r <= (cnt_r == 7'h3 * len) ? 7'h0 : cnt_r + 7'h1;
  end
  assign dom = clamp || (cnt_r != 7'h0 && (cnt_r <= len || cnt_r > 7'h2 * len));
endmodule

// >>> sim/cwf_can_wake_fault_asserts.sv
`timescale 1ns/1ps
module cwf_can_wake_fault_asserts #(
  parameter TXTO_CYC  = 30,
  parameter BUSTO_CYC = 30
) (
  input wire logic       mclk, resetn, trx_mode_we, chip_mode_we, bus_dominant,
  input wire logic       can_tx_in, can_supply_ok, can_rx_out, can_tx_drive_r,
  input wire logic       interrupt_n_out, can_wake_flag, can_failure_flag, can_supply_low_flag,
  input wire logic [1:0] trx_mode_r,
  input wire logic [4:0] chip_mode_wdata, chip_mode_r,
  input wire logic [7:0] wake_status_reg
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic [15:0] tx_cnt, bus_cnt;
  // Dominant run lengths; short sims keep them far from wrapping
  always @(posedge mclk or negedge resetn)
    if (!resetn) {tx_cnt, bus_cnt} <= 32'h0;
    else begin
      tx_cnt <= (trx_mode_r == 2'h3 && !can_tx_in) ? tx_cnt + 16'h1 : 16'h0;
      bus_cnt <= (trx_mode_r[1] && bus_dominant) ? bus_cnt + 16'h1 : 16'h0;
    end
  ////////////////////////////////////////////////////////////////////////
  AST_MODE_01: assert property (can_wake_flag && trx_mode_r == 2'h1 && !trx_mode_we
    |=> trx_mode_r == 2'h1) else $error("mode left wake code");
  AST_FAIL: assert property (chip_mode_we && chip_mode_wdata == 5'h10 && chip_mode_r != 5'h10
    && !trx_mode_we |=> trx_mode_r == 2'h1) else $error("fail entry not wake");
  AST_SLEEP_INT: assert property ($rose(can_wake_flag) && $past(chip_mode_r) == 5'h04
    |-> interrupt_n_out) else $error("sleep wake interrupt");
  AST_RESTART: assert property ($rose(can_wake_flag) && !$past(chip_mode_we)
    && $past(chip_mode_r) inside {5'h04, 5'h08, 5'h10}
    |-> chip_mode_r == 5'h08 && !can_rx_out && wake_status_reg[0]) else $error("no restart");
  AST_STOP: assert property ($rose(can_wake_flag) && !$past(chip_mode_we)
    && $past(chip_mode_r) == 5'h02 |-> !interrupt_n_out && chip_mode_r == 5'h02
    && wake_status_reg[0]) else $error("stop wake");
  AST_TX_TO: assert property (tx_cnt == TXTO_CYC + 3
    |-> can_tx_drive_r && can_failure_flag) else $error("tx timeout");
  AST_TX_BACK: assert property (tx_cnt == 16'h2 && $past(trx_mode_r) == 2'h3
    && can_supply_ok && $past(can_supply_ok) |-> !can_tx_drive_r) else $error("tx off");
  AST_UV: assert property (trx_mode_r == 2'h3 && !can_supply_ok && !trx_mode_we
    |=> can_supply_low_flag && can_tx_drive_r) else $error("undervoltage");
  AST_BUS_TO: assert property (bus_cnt == BUSTO_CYC + 3
    |-> can_failure_flag) else $error("bus clamp");
  cover property ($rose(can_wake_flag) && chip_mode_r == 5'h08);
  cover property (tx_cnt == TXTO_CYC + 3);
  cover property ($rose(can_supply_low_flag));
endmodule
bind cwf_can_wake_fault cwf_can_wake_fault_asserts #(.TXTO_CYC(TXTO_CYC),
  .BUSTO_CYC(BUSTO_CYC)) cwf_can_wake_fault_asserts_i (.*);

// >>> sim/tb.sv
`timescale 1ns/1ps
module tb;
  localparam MN = 3, MX = 20, TO = 30;
  logic mclk = 0, resetn = 0, trx_mode_we = 0, chip_mode_we = 0, restart_done = 0, go = 0;
  logic wake_flag_clr = 0, fail_flag_clr = 0, uv_flag_clr = 0, wdog_on_bus_wake_cfg = 1;
  logic wdog_en_wdata = 0, wdog_en_we = 0, can_rx_bus = 1, can_tx_in = 1, can_supply_ok = 1;
  logic bus_dominant, clamp = 0, can_rx_out, can_tx_drive_r, interrupt_n_out, can_wake_flag;
  logic can_failure_flag, can_supply_low_flag, can_supply_en_r, wdog_en_r;
  logic [1:0]  trx_mode_wdata = 0, trx_mode_r;
  logic [4:0]  chip_mode_wdata = 0, chip_mode_r, len = 5'h0;
  logic [4:0]  lens [4] = '{5'h3, 5'h14, 5'h4, 5'h13};
  logic [7:0]  wake_status_reg;
  logic [31:0] seed = 32'h608e;
  int          n_errors = 0, n_tests = 0;
  cwf_bus_model cwf_bus_model_i (.mclk(mclk), .go(go), .clamp(clamp), .len(len),
    .dom(bus_dominant));
  cwf_can_wake_fault #(.WAKE_MIN_CYC(MN), .WAKE_MAX_CYC(MX), .TXTO_CYC(TO), .BUSTO_CYC(TO))
    cwf_can_wake_fault_i (.*);
  always #50 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Phases must sit strictly inside the window
  function automatic logic wake_ok(input logic [4:0] n);
    return n > MN && n < MX;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    cyc(1);
    s = 0;
    cyc(1);
  endtask
  // Chip code zero means a transceiver mode write
  task automatic wr(input logic [1:0] t, input logic [4:0] c);
    trx_mode_wdata = t;
    chip_mode_wdata = c;
    trx_mode_we = (c == 5'h0);
    chip_mode_we = (c != 5'h0);
    cyc(1);
    {trx_mode_we, chip_mode_we} = 2'h0;
    cyc(1);
  endtask
  task automatic wake(input logic [4:0] n);
    len = n;
    pulse(go);
    cyc(3 * n + 3);
  endtask
  task automatic summarize;
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(5);
    resetn = 1;
    chk({5'h0, trx_mode_r, chip_mode_r, can_rx_out, interrupt_n_out, can_wake_flag,
      can_supply_en_r}, 16'h001c);
    wake(5'h5);
    chk(16'(can_wake_flag), 16'h0);
    wr(2'h1, 5'h0);
    chk(16'(can_supply_en_r), 16'h0);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      wake((i < 4) ? lens[i] : 5'h4 + 5'(seed[3:0]));
      chk(16'({can_wake_flag, can_rx_out, interrupt_n_out, wake_status_reg[0], trx_mode_r}),
        wake_ok(len) ? 16'h25 : 16'h19);
      pulse(wake_flag_clr);
      chk(16'({can_wake_flag, interrupt_n_out}), 16'h1);
    end
    wake(5'h9);
    chk(16'(can_supply_en_r), 16'h1);
    wr(2'h3, 5'h0);
    wr(2'h1, 5'h0);
    chk(16'(can_rx_out), 16'h1);
    wake(5'h9);
    chk(16'(can_rx_out), 16'h0);
    wr(2'h1, 5'h02);
    wake(5'h8);
    chk(16'({chip_mode_r, interrupt_n_out, wdog_en_r}), 16'h9);
    pulse(wdog_en_we);
    wr(2'h1, 5'h02);
    wake(5'h8);
    chk(16'(wdog_en_r), 16'h1);
    wr(2'h2, 5'h0);
    wr(2'h1, 5'h0);
    pulse(wake_flag_clr);
    wr(2'h0, 5'h04);
    wake(5'h6);
    chk(16'({chip_mode_r, interrupt_n_out, can_rx_out}), 16'h22);
    wr(2'h0, 5'h0);
    wr(2'h0, 5'h10);
    chk(16'(trx_mode_r), 16'h1);
    wake(5'h7);
    chk(16'({chip_mode_r, interrupt_n_out, can_rx_out}), 16'h22);
    pulse(restart_done);
    chk(16'(chip_mode_r), 16'h01);
    wr(2'h3, 5'h0);
    can_tx_in = 0;
    cyc(TO + 5);
    chk(16'({can_failure_flag, can_tx_drive_r, trx_mode_r}), 16'hf);
    can_tx_in = 1;
    cyc(2);
    can_tx_in = 0;
    cyc(2);
    chk(16'(can_tx_drive_r), 16'h0);
    can_supply_ok = 0;
    cyc(2);
    chk(16'({can_supply_low_flag, can_tx_drive_r}), 16'h3);
    can_supply_ok = 1;
    cyc(2);
    chk(16'({can_tx_drive_r, trx_mode_r}), 16'h3);
    can_tx_in = 1;
    pulse(uv_flag_clr);
    chk(16'(can_supply_low_flag), 16'h0);
    pulse(fail_flag_clr);
    wr(2'h2, 5'h0);
    clamp = 1;
    cyc(TO + 5);
    clamp = 0;
    chk(16'({can_failure_flag, trx_mode_r}), 16'h6);
    summarize();
  end
endmodule
